// >>> converter_unit.sv
`include "conv_map.svh"
`default_nettype none

module converter_unit
    import conv_pkg::*;
#(
    parameter logic [3:0] ADC_LEN  = `ADC_CYCLES,
    parameter logic [3:0] DAC_LEN  = `DAC_CYCLES,
    parameter logic [1:0] OSC_LAST = `OSC_DIV_LAST
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        timer0_ovf,
    input  wire logic        timer1_ovf,
    input  wire logic        isr_enter,
    input  wire logic        osc_clk,
    input  wire logic [9:0]  adc_code,
    output logic [9:0]       dac_value,
    output logic             unit_enable,
    output logic             dac_mode,
    output logic             diff_mode,
    output logic             analog_connect,
    output logic             int_ref_enable,
    output logic [2:0]       channel_select,
    output logic             conv_busy,
    output logic             conv_clk_tick,
    output logic             conv_done_flag
);

    unit_reg_t   s_q;
    unit_reg_t   s_d;
    reg_sel_t    wr_sel;
    reg_sel_t    rd_sel;
    logic [7:0]  rd_val;
    logic [15:0] res16;
    logic [1:0]  trigger_source_select;
    logic        sw_go;
    logic        tmr_hit;
    logic        start;
    logic        seq_done;

    function automatic reg_sel_t decode(input logic [11:0] addr);
        decode = SEL_NONE;
        if (addr[11:2] == {2'h0, `CTRL_IDX})
            decode = SEL_CTRL;
        if (addr[11:2] == {2'h0, `INCTL_IDX})
            decode = SEL_INCTL;
        if (addr[11:2] == {2'h0, `RES_LOW_IDX})
            decode = SEL_LO;
        if (addr[11:2] == {2'h0, `RES_HIGH_IDX})
            decode = SEL_HI;
    endfunction

    function automatic logic [15:0] align(input logic [9:0] v,
                                          input logic       left);
        align = left ? {v, 6'h00} : {{6{v[9]}}, v};
    endfunction

    function automatic logic [9:0] unalign(input logic [15:0] v,
                                           input logic        left);
        unalign = left ? v[15:6] : v[9:0];
    endfunction

    conv_clock_gen #(
        .OSC_LAST (OSC_LAST)
    ) u_clock_gen (
        .clk       (clk),
        .rst_n     (rst_n),
        .osc_clk   (osc_clk),
        .clk_sel   (s_q.ctrl[`CKS_MSB:0]),
        .conv_tick (conv_clk_tick)
    );

    conv_sequencer #(
        .ADC_LEN (ADC_LEN),
        .DAC_LEN (DAC_LEN)
    ) u_sequencer (
        .clk       (clk),
        .rst_n     (rst_n),
        .start     (start),
        .dac_mode  (s_q.ctrl[`BIT_DAC]),
        .conv_tick (conv_clk_tick),
        .busy      (conv_busy),
        .done      (seq_done)
    );

    always_comb begin
        s_d    = s_q;
        wr_sel = SEL_NONE;
        rd_sel = SEL_NONE;
        rd_val = 8'h00;
        res16  = align(s_q.result, s_q.ctrl[`BIT_LEFT_ALIGN_SELECT]);
        sw_go  = 1'b0;
        // Converter result is held steady by the analog side at the end
        s_d.code_s1 = adc_code;
        s_d.code_s2 = s_q.code_s1;

        if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;
        if (s_q.rvalid && s_axi_rready)
            s_d.rvalid = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_axi_wdata[7:0];
            s_d.w_strb = s_axi_wstrb[0];
        end

        if (s_d.aw_have && s_d.w_have) begin
            wr_sel      = decode(s_d.aw_addr);
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = (wr_sel == SEL_NONE) ? `RESP_DECERR
                                               : `RESP_OKAY;
            if (s_d.w_strb) begin
                unique case (wr_sel)
                    SEL_CTRL: begin
                        // Done flag and busy bit are hardware owned
                        s_d.ctrl[`BIT_DAC:0] = s_d.w_data[`BIT_DAC:0];
                        sw_go = s_d.w_data[`BIT_GO];
                    end
                    SEL_INCTL: s_d.inctl = s_d.w_data;
                    SEL_LO: if (s_q.ctrl[`BIT_DAC])
                        s_d.data_lo = s_d.w_data;
                    SEL_HI: if (s_q.ctrl[`BIT_DAC])
                        s_d.data_hi = s_d.w_data;
                    SEL_NONE: ;
                endcase
            end
        end

        trigger_source_select     = s_d.inctl[`TRG_MSB:0];
        tmr_hit = (trigger_source_select == TRG_TMR0 && timer0_ovf)
                  || (trigger_source_select == TRG_TMR1 && timer1_ovf);
        start   = s_d.ctrl[`BIT_EN] && !conv_busy
                  && ((sw_go && trigger_source_select == TRG_SOFT) || tmr_hit);

        if (start && s_d.ctrl[`BIT_DAC])
            s_d.dac_buf = unalign({s_d.data_hi, s_d.data_lo},
                                  s_d.ctrl[`BIT_LEFT_ALIGN_SELECT]);
        if (seq_done && !s_q.ctrl[`BIT_DAC])
            s_d.result = s_q.code_s2;
        if (isr_enter)
            s_d.ctrl[`BIT_DONE] = 1'b0;
        if (seq_done)
            s_d.ctrl[`BIT_DONE] = 1'b1;

        if (s_axi_arvalid && s_axi_arready) begin
            rd_sel = decode(s_axi_araddr);
            unique case (rd_sel)
                SEL_CTRL: rd_val = {s_q.ctrl[`BIT_DONE], conv_busy,
                                    s_q.ctrl[`BIT_DAC:0]};
                SEL_INCTL: rd_val = s_q.inctl;
                SEL_LO: rd_val = s_q.ctrl[`BIT_DAC] ? 8'h00 : res16[7:0];
                SEL_HI: rd_val = s_q.ctrl[`BIT_DAC] ? 8'h00 : res16[15:8];
                SEL_NONE: rd_val = 8'h00;
            endcase
            s_d.rvalid = 1'b1;
            s_d.rdata  = {24'h00_0000, rd_val};
            s_d.rresp  = (rd_sel == SEL_NONE) ? `RESP_DECERR
                                              : `RESP_OKAY;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q       <= '0;
            s_q.ctrl  <= `CTRL_RESET;
            s_q.inctl <= `INCTL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready  = !s_q.aw_have && !s_q.bvalid;
    assign s_axi_wready   = !s_q.w_have && !s_q.bvalid;
    assign s_axi_bvalid   = s_q.bvalid;
    assign s_axi_bresp    = s_q.bresp;
    assign s_axi_arready  = !s_q.rvalid;
    assign s_axi_rvalid   = s_q.rvalid;
    assign s_axi_rdata    = s_q.rdata;
    assign s_axi_rresp    = s_q.rresp;
    assign dac_value      = s_q.dac_buf;
    assign unit_enable    = s_q.ctrl[`BIT_EN];
    assign dac_mode       = s_q.ctrl[`BIT_DAC];
    assign conv_done_flag = s_q.ctrl[`BIT_DONE];
    assign diff_mode      = s_q.inctl[`BIT_DIFF];
    assign analog_connect = s_q.inctl[`BIT_ACON];
    assign int_ref_enable = s_q.inctl[`BIT_IREF];
    assign channel_select = s_q.inctl[`ACS_MSB:`ACS_LSB];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_sw_go_enabled;
        sw_go && trigger_source_select == TRG_SOFT && s_d.ctrl[`BIT_EN] && !conv_busy;
    endsequence

    property p_sw_start;
        s_sw_go_enabled |=> conv_busy ##1 conv_busy;
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start did not launch a conversion");

    property p_timer_start;
        tmr_hit && s_d.ctrl[`BIT_EN] && !conv_busy |=> conv_busy;
    endproperty
    a_timer_start: assert property (p_timer_start)
        else $error("timer overflow did not launch a conversion");

    property p_busy_read;
        s_axi_arvalid && s_axi_arready
            && decode(s_axi_araddr) == SEL_CTRL && conv_busy
        |=> s_axi_rdata[`BIT_GO];
    endproperty
    a_busy_read: assert property (p_busy_read)
        else $error("busy bit not shown while converting");

    property p_no_start_off;
        (sw_go || tmr_hit) && !s_d.ctrl[`BIT_EN] && !conv_busy
        |=> !conv_busy;
    endproperty
    a_no_start_off: assert property (p_no_start_off)
        else $error("conversion started while disabled");

    property p_wrong_trig;
        sw_go && trigger_source_select != TRG_SOFT && !tmr_hit && !conv_busy
        |=> !conv_busy;
    endproperty
    a_wrong_trig: assert property (p_wrong_trig)
        else $error("software start honoured in timer mode");

    property p_done_set;
        seq_done |=> conv_done_flag;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done flag not set at conversion end");

    property p_done_clr;
        isr_enter && !seq_done |=> !conv_done_flag;
    endproperty
    a_done_clr: assert property (p_done_clr)
        else $error("done flag not cleared on service entry");

    property p_dir;
        wr_sel == SEL_CTRL && s_d.w_strb
        |=> dac_mode == $past(s_d.w_data[`BIT_DAC]);
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction bit not taken from write");

    property p_left_zero;
        s_axi_arvalid && s_axi_arready && !dac_mode && s_q.ctrl[`BIT_LEFT_ALIGN_SELECT]
            && decode(s_axi_araddr) == SEL_LO
        |=> s_axi_rdata[5:0] == 6'h00;
    endproperty
    a_left_zero: assert property (p_left_zero)
        else $error("left aligned low bits not zero");

    property p_right_sign;
        s_axi_arvalid && s_axi_arready && !dac_mode
            && !s_q.ctrl[`BIT_LEFT_ALIGN_SELECT] && decode(s_axi_araddr) == SEL_HI
        |=> s_axi_rdata[7:1] == {7{s_axi_rdata[1]}};
    endproperty
    a_right_sign: assert property (p_right_sign)
        else $error("right aligned result not sign extended");

    property p_buf_hold;
        conv_busy && dac_mode |=> $stable(dac_value);
    endproperty
    a_buf_hold: assert property (p_buf_hold)
        else $error("output buffer changed during conversion");

    property p_result_hold;
        !seq_done |=> $stable(s_q.result);
    endproperty
    a_result_hold: assert property (p_result_hold)
        else $error("result changed outside completion");

    property p_done_end;
        seq_done |=> !conv_busy && conv_done_flag;
    endproperty
    a_done_end: assert property (p_done_end)
        else $error("busy not cleared at conversion end");

    property p_done_src;
        $rose(conv_done_flag) |-> $past(seq_done);
    endproperty
    a_done_src: assert property (p_done_src)
        else $error("done flag set without completion");

    property p_reset;
        disable iff (1'b0)
        !rst_n |=> s_q.ctrl == 8'h00 && !conv_busy;
    endproperty
    a_reset: assert property (p_reset)
        else $error("control register not zero after reset");

endmodule // converter_unit

`default_nettype wire

// >>> conv_map.svh
`ifndef CONV_MAP_SVH
`define CONV_MAP_SVH

// Register indices; byte address is index times four
`define CTRL_IDX      8'hd9
`define INCTL_IDX     8'hda
`define RES_LOW_IDX   8'hdc
`define RES_HIGH_IDX  8'hdd

`define CTRL_RESET    8'h00
`define INCTL_RESET   8'h00

// Control register fields
`define BIT_DONE      7
`define BIT_GO        6
`define BIT_DAC       5
`define BIT_EN        4
`define BIT_LEFT_ALIGN_SELECT      3
`define CKS_MSB       2

// Input control register fields
`define BIT_ACON      7
`define BIT_IREF      6
`define ACS_MSB       5
`define ACS_LSB       3
`define BIT_DIFF      2
`define TRG_MSB       1

// Converter clock cycles per conversion
`define ADC_CYCLES    4'hd
`define DAC_CYCLES    4'hb
// Oscillator edges per converter tick, minus one
`define OSC_DIV_LAST  2'h3

`define RESP_OKAY     2'h0
`define RESP_DECERR   2'h3

`endif

// >>> conv_pkg.sv
`default_nettype none

package conv_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_RUN  = 2'h1,
        SEQ_END  = 2'h3
    } seq_state_t;

    typedef enum logic [1:0] {
        TRG_SOFT = 2'h0,
        TRG_TMR0 = 2'h1,
        TRG_TMR1 = 2'h2
    } trig_t;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_CTRL, SEL_INCTL, SEL_LO, SEL_HI
    } reg_sel_t;

    typedef struct packed {
        seq_state_t state;
        logic [3:0] cnt;
        logic       dac;
    } seq_reg_t;

    typedef struct packed {
        logic [2:0] osc_sync;
        logic [1:0] osc_cnt;
        logic [6:0] presc;
        logic       tick;
    } clk_reg_t;

    typedef struct packed {
        logic        aw_have;
        logic [11:0] aw_addr;
        logic        w_have;
        logic [7:0]  w_data;
        logic        w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  ctrl;
        logic [7:0]  inctl;
        logic [7:0]  data_lo;
        logic [7:0]  data_hi;
        logic [9:0]  result;
        logic [9:0]  dac_buf;
        logic [9:0]  code_s1;
        logic [9:0]  code_s2;
    } unit_reg_t;

endpackage : conv_pkg

`default_nettype wire

// >>> conv_clock_gen.sv
`include "conv_map.svh"
`default_nettype none

module conv_clock_gen
    import conv_pkg::*;
#(
    parameter logic [1:0] OSC_LAST = `OSC_DIV_LAST
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       osc_clk,
    input  wire logic [2:0] clk_sel,
    output logic            conv_tick
);

    clk_reg_t   s_q;
    clk_reg_t   s_d;
    logic       osc_rise;
    logic [6:0] gap_q;
    logic       sel_same_q;

    function automatic logic [6:0] div_mask(input logic [2:0] sel);
        div_mask = 7'h7f >> (3'h7 - sel);
    endfunction

    // Oscillator sampled by two flops, third flop only for edge finding
    always_comb begin
        s_d = s_q;
        s_d.osc_sync = {s_q.osc_sync[1:0], osc_clk};
        osc_rise = s_q.osc_sync[1] && !s_q.osc_sync[2];
        s_d.presc = s_q.presc + 7'h01;
        if (clk_sel == 3'h0) begin
            s_d.tick = osc_rise && s_q.osc_cnt == OSC_LAST;
            if (osc_rise)
                s_d.osc_cnt = s_q.osc_cnt + 2'h1;
        end else begin
            s_d.tick = (s_q.presc & div_mask(clk_sel))
                       == div_mask(clk_sel);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign conv_tick = s_q.tick;

    // Cycles since last tick, for checking the divide ratio
    always_ff @(posedge clk) begin
        if (!rst_n || conv_tick) begin
            gap_q      <= 7'h00;
            sel_same_q <= rst_n;
        end else begin
            gap_q      <= gap_q + 7'h01;
            if (clk_sel != $past(clk_sel))
                sel_same_q <= 1'b0;
        end
    end

    property p_div;
        @(posedge clk) disable iff (!rst_n)
        conv_tick && clk_sel != 3'h0 && sel_same_q
            && clk_sel == $past(clk_sel)
        |-> gap_q == div_mask(clk_sel);
    endproperty
    a_div: assert property (p_div)
        else $error("converter clock divide ratio wrong");

endmodule // conv_clock_gen

`default_nettype wire

// >>> conv_sequencer.sv
`include "conv_map.svh"
`default_nettype none

module conv_sequencer
    import conv_pkg::*;
#(
    parameter logic [3:0] ADC_LEN = `ADC_CYCLES,
    parameter logic [3:0] DAC_LEN = `DAC_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start,
    input  wire logic dac_mode,
    input  wire logic conv_tick,
    output logic      busy,
    output logic      done
);

    seq_reg_t   s_q;
    seq_reg_t   s_d;
    logic [3:0] len;
    logic [3:0] ticks_q;

    always_comb begin
        s_d = s_q;
        len = s_q.dac ? DAC_LEN : ADC_LEN;
        unique case (s_q.state)
            SEQ_IDLE: if (start) begin
                s_d.state = SEQ_RUN;
                s_d.cnt   = 4'h0;
                s_d.dac   = dac_mode;
            end
            SEQ_RUN: if (conv_tick) begin
                if (s_q.cnt == len - 4'h1)
                    s_d.state = SEQ_END;
                else
                    s_d.cnt = s_q.cnt + 4'h1;
            end
            SEQ_END: s_d.state = SEQ_IDLE;
            default: s_d.state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign busy = s_q.state != SEQ_IDLE;
    assign done = s_q.state == SEQ_END;

    always_ff @(posedge clk) begin
        if (!rst_n || s_q.state == SEQ_IDLE)
            ticks_q <= 4'h0;
        else if (s_q.state == SEQ_RUN && conv_tick)
            ticks_q <= ticks_q + 4'h1;
    end

    sequence s_launch;
        start && !busy;
    endsequence

    sequence s_hold_busy;
        busy [*8];
    endsequence

    property p_busy_hold;
        @(posedge clk) disable iff (!rst_n)
        s_launch |=> s_hold_busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped early in a conversion");

    property p_len;
        @(posedge clk) disable iff (!rst_n)
        done |-> ticks_q == (s_q.dac ? DAC_LEN : ADC_LEN);
    endproperty
    a_len: assert property (p_len)
        else $error("conversion length in ticks wrong");

    property p_clear;
        @(posedge clk) disable iff (!rst_n)
        $fell(busy) |-> $past(done);
    endproperty
    a_clear: assert property (p_clear)
        else $error("busy cleared without completion");

endmodule // conv_sequencer

`default_nettype wire

// >>> analog_model.sv
`default_nettype none

module analog_model (
    input  wire logic [2:0] channel_select,
    input  wire logic       analog_connect,
    output logic            osc_clk,
    output logic [9:0]      adc_code
);
    timeunit 1ns;
    timeprecision 100ps;

    // Internal oscillator runs free at 8 MHz
    initial begin
        osc_clk = 1'b0;
        forever #62.5 osc_clk = ~osc_clk;
    end

    // Code follows channel and holds while it is fixed; open input inverts
    always_comb adc_code = analog_connect ? {channel_select, 7'h2a}
                                          : ~{channel_select, 7'h2a};
endmodule // analog_model

`default_nettype wire

// >>> converter_unit_bench.sv
`include "conv_map.svh"
`default_nettype none

module converter_unit_bench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [11:0] A_CTRL = {2'h0, `CTRL_IDX, 2'h0};
    localparam logic [11:0] A_INCTL = {2'h0, `INCTL_IDX, 2'h0};
    localparam logic [11:0] A_LO = {2'h0, `RES_LOW_IDX, 2'h0};
    localparam logic [11:0] A_HI = {2'h0, `RES_HIGH_IDX, 2'h0};

    logic        clk, rst_n, awv, wv, bre, arv, rre, t0, t1, isr;
    logic [11:0] awa, ara;
    logic [31:0] wd, rd_d;
    logic        awr, wrd, bv, arr, rv, osc, en, dm, busy, tick, done;
    logic [1:0]  br, rr;
    logic [9:0]  code, dac;
    logic [2:0]  ch;
    logic        acon, busy_q, dif, iref;
    int          errors, checked, ticks, starts;
    logic [15:0] v;
    int          g;

    converter_unit i_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .timer0_ovf(t0), .timer1_ovf(t1),
        .isr_enter(isr), .osc_clk(osc), .adc_code(code), .dac_value(dac),
        .unit_enable(en), .dac_mode(dm), .diff_mode(dif),
        .analog_connect(acon), .int_ref_enable(iref), .channel_select(ch),
        .conv_busy(busy), .conv_clk_tick(tick), .conv_done_flag(done));

    analog_model i_analog (.channel_select(ch), .analog_connect(acon),
        .osc_clk(osc), .adc_code(code));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Converter ticks within each conversion, and conversions begun
    always @(posedge clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            ticks  <= 0;
            starts <= 0;
        end else begin
            busy_q <= busy;
            if (busy && !busy_q) begin
                ticks <= int'(tick);
                starts <= starts + 1;
            end else if (busy && tick) begin
                ticks <= ticks + 1;
            end
        end
    end

    task automatic close_out();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] s);
        checked++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int  n;
        logic ta, tw, tb;
        n = 0;
        tb = 1'b0;
        @(posedge clk);
        awa <= a;
        awv <= 1'b1;
        wd <= {24'h00_0000, d};
        wv <= 1'b1;
        bre <= 1'b1;
        while (!tb && n < 100) begin
            @(negedge clk);
            ta = awv && awr;
            tw = wv && wrd;
            tb = bv && bre;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb) bre <= 1'b0;
            n++;
        end
        if (!tb) begin
            errors++;
            close_out();
        end
    endtask

    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        int  n;
        logic ta, tr;
        n = 0;
        tr = 1'b0;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        while (!tr && n < 100) begin
            @(negedge clk);
            ta = arv && arr;
            tr = rv && rre;
            d = {rr, 6'h00, rd_d[7:0]};
            @(posedge clk);
            if (ta) arv <= 1'b0;
            if (tr) rre <= 1'b0;
            n++;
        end
        if (!tr) begin
            errors++;
            close_out();
        end
    endtask

    // Wait for the end of a conversion and judge its length and flag
    task automatic finish_conv(input int len, input int nst);
        int n;
        n = 0;
        @(negedge clk);
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000) begin
            errors++;
            close_out();
        end
        chk("ticks", 16'(len), 16'(ticks));
        chk("starts", 16'(nst), 16'(starts));
        chk("done", 16'h0001, {15'h0000, done});
    endtask

    task automatic pulse(input logic which);
        @(posedge clk);
        t0 <= !which;
        t1 <= which;
        @(posedge clk);
        t0 <= 1'b0;
        t1 <= 1'b0;
        @(negedge clk);
    endtask

    task automatic service();
        @(posedge clk);
        isr <= 1'b1;
        @(posedge clk);
        isr <= 1'b0;
        @(negedge clk);
        chk("done clear", 16'h0000, {15'h0000, done});
    endtask

    initial begin
        {awv, wv, bre, arv, rre, t0, t1, isr} = '0;
        {awa, ara, wd, errors, checked} = '0;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(A_CTRL, v);
        chk("ctrl reset", 16'h0000, v);
        rd(A_INCTL, v);
        chk("inctl reset", 16'h0000, v);
        rd(12'h3fc, v);
        chk("unmapped", {`RESP_DECERR, 14'h0000}, v);
        wr(A_CTRL, 8'h40);
        repeat (3) @(negedge clk);
        chk("off start", 16'h0000, {15'h0000, busy});
        rd(A_CTRL, v);
        chk("off ctrl", 16'h0000, v);
        // Channel five connected, left fixed for every conversion
        wr(A_INCTL, 8'hec);
        chk("inctl pins", 16'h003b, {10'h000, acon, iref, ch, dif});
        wr(A_CTRL, 8'h51);
        chk("enable", 16'h0001, {15'h0000, en});
        rd(A_CTRL, v);
        chk("busy bit", 16'h0051, v);
        finish_conv(13, 1);
        rd(A_CTRL, v);
        chk("ctrl end", 16'h0091, v);
        rd(A_HI, v);
        chk("right high", 16'h00fe, v);
        rd(A_LO, v);
        chk("right low", 16'h00aa, v);
        service();
        wr(A_CTRL, 8'h58);
        finish_conv(13, 2);
        rd(A_HI, v);
        chk("left high", 16'h00aa, v);
        rd(A_LO, v);
        chk("left low", 16'h0080, v);
        for (int s = 1; s < 8; s++) begin
            wr(A_CTRL, 8'(s));
            repeat (2) begin
                g = 0;
                do begin
                    @(negedge clk);
                    g++;
                end while (tick !== 1'b1 && g < 300);
            end
            chk("tick gap", 16'(1 << s), 16'(g));
        end
        for (int c = 1; c < 3; c++) begin
            wr(A_INCTL, 8'ha8 | 8'(c));
            // Software start in timer mode must be ignored
            wr(A_CTRL, 8'h51);
            pulse(c == 1);
            repeat (3) @(negedge clk);
            chk("other timer", 16'h0000, {15'h0000, busy});
            // Overflows spaced wider than one conversion
            for (int k = 0; k < 2; k++) begin
                pulse(c == 2);
                chk("timer busy", 16'h0001, {15'h0000, busy});
                rd(A_CTRL, v);
                chk("timer bit", 16'h0001, {15'h0000, v[6]});
                finish_conv(13, 2 * c + k + 1);
                service();
            end
        end
        wr(A_INCTL, 8'ha8);
        // Converter clock no faster than the system clock
        wr(A_CTRL, 8'h31);
        chk("dac mode", 16'h0001, {15'h0000, dm});
        wr(A_LO, 8'h34);
        wr(A_HI, 8'h02);
        wr(A_CTRL, 8'h71);
        chk("dac load", 16'h0234, {6'h00, dac});
        wr(A_LO, 8'h00);
        finish_conv(11, 7);
        chk("dac held", 16'h0234, {6'h00, dac});
        rd(A_LO, v);
        chk("dac low rd", 16'h0000, v);
        close_out();
    end
endmodule // converter_unit_bench

`default_nettype wire
